// ### bench/tb.sv
// Self-checking bench for the watchdog / interval timer, APB master and model.
// Assumes the design files are compiled first and a single clk_sys domain.
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ==========================================================
  // Signals
  logic        clk_sys           = 1'b0;
  logic        sys_rst           = 1'b1;
  logic        ce                = 1'b1;
  logic        psel              = 1'b0;
  logic        penable           = 1'b0;
  logic        pwrite            = 1'b0;
  logic [11:0] paddr             = 12'h000;
  logic [31:0] pwdata            = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        smclk             = 1'b0;
  logic        aclk              = 1'b0;
  logic        rst_nmi_pin_n     = 1'b1;
  logic        global_irq_enable = 1'b1;
  logic        timer_irq_ack     = 1'b0;
  logic        power_up_clear_reset;
  logic        pin_reset_request;
  logic        timer_irq;
  logic        nmi_irq;
  logic        smclk_keep_on;
  int          errors            = 0;
  int          total_checks      = 0;
  int          puc_count         = 0;
  logic [31:0] rd;
  logic        err;
  // Model state: control low byte, enables, flags
  logic [7:0]  exp_ctl           = 8'h00;
  logic [7:0]  exp_ie            = 8'h00;
  logic [7:0]  exp_ifg           = 8'h00;

  localparam logic [11:0] a_ie  = 12'h000;
  localparam logic [11:0] a_ifg = 12'h008;
  localparam logic [11:0] a_ctl = 12'h480;

  always #5 clk_sys = ~clk_sys;

  // Count power-up clear pulses seen on the output
  always @(posedge clk_sys) begin
    if (power_up_clear_reset === 1'b1) begin
      puc_count <= puc_count + 1;
    end
  end

  watchdog_interval_timer #(.ENHANCED_VARIANT(1'b1)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smclk(smclk), .aclk(aclk), .rst_nmi_pin_n(rst_nmi_pin_n),
    .global_irq_enable(global_irq_enable), .timer_irq_ack(timer_irq_ack),
    .power_up_clear_reset(power_up_clear_reset), .pin_reset_request(pin_reset_request),
    .timer_irq(timer_irq), .nmi_irq(nmi_irq), .smclk_keep_on(smclk_keep_on)
  );

  // ==========================================================
  // Tasks
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One APB transfer; waits for pready under a bounded count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(rd, want);
  endtask

  // Power-up clear as the model sees it; timer flag set, NMI flag cleared
  task automatic model_puc();
    exp_ctl = 8'h00;
    exp_ie = 8'h00;
    exp_ifg[4] = 1'b0;
    exp_ifg[0] = 1'b1;
  endtask

  task automatic wctl(input logic [7:0] key, input logic [7:0] v);
    apb(1'b1, a_ctl, {16'h0000, key, v});
    if (key == 8'h5a) begin
      exp_ctl = v & 8'hf7;
    end else begin
      model_puc();
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask

  // Source edges with a period of 8 system cycles; idle low between
  task automatic src(input logic sel, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (sel) aclk <= 1'b1;
      else smclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      aclk  <= 1'b0;
      smclk <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    int want_puc;
    logic [7:0] key;
    logic [31:0] d;
    void'($urandom(5));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;

    // Reset values, unmapped access, keep-on in watchdog/SMCLK
    rchk(a_ctl, 32'h0000_6900);
    rchk(a_ie, 32'h0);
    rchk(a_ifg, 32'h0);
    check(smclk_keep_on, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    check(err, 1'b1);
    done("reset");

    // Interval mode on ACLK: clear mid-count, exact expiry, irq gating
    apb(1'b1, a_ie, 32'h0000_0001);
    exp_ie = 8'h01;
    for (int code = 3; code >= 2; code--) begin
      n = (code == 3) ? 64 : 512;
      wctl(8'h5a, 8'h1c | code[7:0]);
      rchk(a_ctl, {16'h0000, 8'h69, exp_ctl});
      check(smclk_keep_on, 1'b0);
      src(1'b1, n / 2);
      wctl(8'h5a, 8'h1c | code[7:0]);
      src(1'b1, n - 1);
      settle();
      rchk(a_ifg, 32'h0);
      src(1'b1, 1);
      settle();
      exp_ifg[0] = 1'b1;
      rchk(a_ifg, {24'h0, exp_ifg});
      check(timer_irq, 1'b1);
      check(puc_count, 0);
      global_irq_enable <= 1'b0;
      settle();
      check(timer_irq, 1'b0);
      global_irq_enable <= 1'b1;
      @(posedge clk_sys);
      timer_irq_ack <= 1'b1;
      @(posedge clk_sys);
      timer_irq_ack <= 1'b0;
      settle();
      exp_ifg[0] = 1'b0;
      check(timer_irq, 1'b0);
      rchk(a_ifg, {24'h0, exp_ifg});
    end
    done("interval");

    // Hold freezes the count; releasing it lets 64 edges expire
    wctl(8'h5a, 8'h9f);
    src(1'b1, 64);
    settle();
    rchk(a_ifg, 32'h0);
    wctl(8'h5a, 8'h17);
    src(1'b1, 64);
    settle();
    rchk(a_ifg, 32'h1);
    apb(1'b1, a_ifg, 32'h0);
    // Clock enable low freezes synchronisers and counter
    ce <= 1'b0;
    src(1'b1, 64);
    ce <= 1'b1;
    settle();
    rchk(a_ifg, 32'h0);
    src(1'b1, 64);
    settle();
    rchk(a_ifg, 32'h1);
    apb(1'b1, a_ifg, 32'h0);
    exp_ifg = 8'h00;
    done("hold");

    // Watchdog on SMCLK: ACLK edges ignored, SMCLK expiry clears control and enables, sets timer flag
    wctl(8'h5a, 8'h0b);
    src(1'b1, 64);
    settle();
    check(puc_count, 0);
    src(1'b0, 64);
    settle();
    check(puc_count, 1);
    model_puc();
    rchk(a_ctl, 32'h0000_6900);
    rchk(a_ifg, {24'h0, exp_ifg});
    rchk(a_ie, 32'h0);
    done("watchdog");

    // Random bad keys, random enable contents wiped by the clear
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      apb(1'b1, a_ie, d);
      exp_ie = d[7:0] & 8'h11;
      rchk(a_ie, {24'h0, exp_ie});
      apb(1'b1, a_ifg, 32'h0);
      exp_ifg = 8'h00;
      key = 8'($urandom);
      if (key == 8'h5a) key = 8'ha5;
      want_puc = puc_count + 1;
      wctl(key, 8'($urandom));
      settle();
      check(puc_count, want_puc);
      rchk(a_ctl, 32'h0000_6900);
      rchk(a_ifg, 32'h1);
      rchk(a_ie, 32'h0);
    end
    done("key");

    // Pin in NMI function: rising, then falling edge select; then reset function request
    apb(1'b1, a_ie, 32'h0000_0010);
    wctl(8'h5a, 8'ha0);
    rst_nmi_pin_n <= 1'b0;
    settle();
    check(pin_reset_request, 1'b0);
    check(nmi_irq, 1'b0);
    rst_nmi_pin_n <= 1'b1;
    settle();
    check(nmi_irq, 1'b1);
    rchk(a_ifg, 32'h11);
    apb(1'b1, a_ifg, 32'h0);
    settle();
    check(nmi_irq, 1'b0);
    wctl(8'h5a, 8'he0);
    settle();
    check(nmi_irq, 1'b0);
    rst_nmi_pin_n <= 1'b0;
    settle();
    check(nmi_irq, 1'b1);
    apb(1'b1, a_ifg, 32'h0);
    apb(1'b1, a_ie, 32'h0);
    rst_nmi_pin_n <= 1'b1;
    settle();
    rst_nmi_pin_n <= 1'b0;
    settle();
    check(nmi_irq, 1'b0);
    rchk(a_ifg, 32'h10);
    wctl(8'h5a, 8'h80);
    settle();
    check(pin_reset_request, 1'b1);
    rst_nmi_pin_n <= 1'b1;
    settle();
    check(pin_reset_request, 1'b0);
    done("pin");

    // Timer flag survives power-up clear, not a power-on reset
    wctl(8'h00, 8'h00);
    settle();
    rchk(a_ifg, 32'h1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk(a_ifg, 32'h0);
    done("power-on");

    final_report();
  end
endmodule

`default_nettype wire

// ### design/clock_source_sync.sv
// Synchronises the two timer source clocks and makes a tick per rising edge of the selected one.
// Assumes both sources run well below half of clk_sys.
`timescale 1ns/10ps
`default_nettype none

module clock_source_sync (
  // System
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic ce,
  // Sources
  input  wire logic smclk,
  input  wire logic aclk,
  input  wire logic src_sel,
  // Result
  output logic      tick
);

  logic [1:0] raw;
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_c;

  assign raw = {aclk, smclk};

  // ==========================================================
  // Two-flop synchroniser plus edge flop per source
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_src
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          sync_a[i] <= 1'b0;
          sync_b[i] <= 1'b0;
          sync_c[i] <= 1'b0;
        end else if (ce) begin
          sync_a[i] <= raw[i];
          sync_b[i] <= sync_a[i];
          sync_c[i] <= sync_b[i];
        end
      end
    end
  endgenerate

  // Stopped source gives no ticks, so the counter just waits
  assign tick = sync_b[src_sel] & ~sync_c[src_sel];

endmodule
`default_nettype wire

// ### design/expiry_counter.sv
// Sixteen-bit up-counter with hold, clear and interval expiry pulse.
// Assumes tick is a one-cycle pulse on clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defines.svh"

module expiry_counter (
  // System
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  // Control
  input  wire logic                    clear,
  input  wire logic                    hold,
  input  wire logic                    tick,
  input  wire wdt_pkg::interval_code_t interval_select,
  // Result
  output logic [15:0]                  count,
  output logic                         expiry
);

  logic [15:0] mask;

  // Low-bit mask of the selected divider
  always_comb begin
    case (interval_select)
      2'h0:    mask = 16'hffff >> (16 - `DIV_BITS_0);
      2'h1:    mask = 16'hffff >> (16 - `DIV_BITS_1);
      2'h2:    mask = 16'hffff >> (16 - `DIV_BITS_2);
      default: mask = 16'hffff >> (16 - `DIV_BITS_3);
    endcase
  end

  // Carry into the divider bit marks expiry
  assign expiry = tick & ~hold & ~clear & ((count & mask) == mask);

  // ==========================================================
  // Count; clear beats hold so a held timer can still be reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 16'h0000;
    end else if (ce) begin
      if (clear) begin
        count <= 16'h0000;
      end else if (tick && !hold) begin
        count <= count + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ### design/watchdog_interval_timer.sv
// Watchdog / interval timer with key-protected control and shared SFR bits.
// Assumes an APB master on clk_sys and sys_rst as the power-on reset.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defines.svh"

module watchdog_interval_timer #(
  parameter bit ENHANCED_VARIANT = 1'b0
) (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer source clocks (pins)
  input  wire logic        smclk,
  input  wire logic        aclk,
  // Reset/NMI pin, active low for reset
  input  wire logic        rst_nmi_pin_n,
  // CPU side
  input  wire logic        global_irq_enable,
  input  wire logic        timer_irq_ack,
  // Results
  output logic             power_up_clear_reset,
  output logic             pin_reset_request,
  output logic             timer_irq,
  output logic             nmi_irq,
  output logic             smclk_keep_on
);

  // ==========================================================
  // Declarations
  wdt_pkg::bus_state_t     state;
  wdt_pkg::interval_code_t interval_select;
  logic        counter_hold;
  logic        pin_edge_select;
  logic        pin_function_select;
  logic        interval_mode_select;
  logic        source_clock_select;
  logic        timer_irq_enable;
  logic        nonmaskable_irq_enable;
  logic        timer_expiry_flag;
  logic        nmi_flag;
  logic        pin_s1;
  logic        pin_s2;
  logic        nmi_prev;
  logic        nmi_level;
  logic        nmi_edge;
  logic        tick;
  logic        expiry;
  logic [15:0] internal_counter;
  logic        hit_ctl;
  logic        hit_ie;
  logic        hit_ifg;
  logic        wr_commit;
  logic        key_bad;
  logic        ctl_ok;
  logic        counter_clear;
  logic        sw_flag_wr;
  logic        watchdog_trip;
  logic [15:0] ctl_read;
  logic [7:0]  ie_read;
  logic [7:0]  ifg_read;
  logic [31:0] next_prdata;

  // ==========================================================
  // Address decode
  assign hit_ctl = (paddr[11:2] == 10'(`IDX_WDOG_CTRL)) && (paddr[1:0] == 2'b00);
  assign hit_ie  = (paddr[11:2] == 10'(`IDX_IRQ_ENABLE)) && (paddr[1:0] == 2'b00);
  assign hit_ifg = (paddr[11:2] == 10'(`IDX_IRQ_FLAG)) && (paddr[1:0] == 2'b00);

  // Writes take effect only at the completing edge
  assign wr_commit  = psel & penable & pready & pwrite;
  assign key_bad    = wr_commit & hit_ctl & (pwdata[15:8] != `KEY_WRITE);
  assign ctl_ok     = wr_commit & hit_ctl & ~key_bad;
  assign sw_flag_wr = wr_commit & hit_ifg;

  // Clear bit is a pulse, never stored; reset also restarts count
  assign counter_clear = (ctl_ok & pwdata[`CTL_CLEAR]) | power_up_clear_reset;

  // Expiry resets only in watchdog mode, enable bit not consulted
  assign watchdog_trip = expiry & ~interval_mode_select;

  // ==========================================================
  // Read values; unused shared bits read zero
  assign ctl_read = {`KEY_READ, counter_hold, pin_edge_select,
                     pin_function_select, interval_mode_select,
                     1'b0, source_clock_select, interval_select};
  assign ie_read  = {3'h0, nonmaskable_irq_enable, 3'h0, timer_irq_enable};
  assign ifg_read = {3'h0, nmi_flag, 3'h0, timer_expiry_flag};

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctl) begin
      next_prdata = {16'h0000, ctl_read};
    end else if (hit_ie) begin
      next_prdata = {24'h00_0000, ie_read};
    end else if (hit_ifg) begin
      next_prdata = {24'h00_0000, ifg_read};
    end
  end

  // ==========================================================
  // APB slave: one wait state, answer from flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= wdt_pkg::BUS_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      case (state)
        wdt_pkg::BUS_IDLE: begin
          if (psel && penable) begin
            state   <= wdt_pkg::BUS_RESP;
            pready  <= 1'b1;
            pslverr <= ~(hit_ctl | hit_ie | hit_ifg);
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
          end
        end
        wdt_pkg::BUS_RESP: begin
          state   <= wdt_pkg::BUS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          state  <= wdt_pkg::BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Power-up clear pulse; violation or watchdog expiry
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      power_up_clear_reset <= 1'b0;
    end else if (ce) begin
      power_up_clear_reset <= key_bad | watchdog_trip;
    end
  end

  // ==========================================================
  // Control fields; reset gives watchdog, SMCLK, /32768, running
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      counter_hold         <= 1'b0;
      pin_edge_select      <= 1'b0;
      pin_function_select  <= 1'b0;
      interval_mode_select <= 1'b0;
      source_clock_select  <= 1'b0;
      interval_select      <= 2'h0;
    end else if (ce) begin
      if (power_up_clear_reset) begin
        counter_hold         <= 1'b0;
        pin_edge_select      <= 1'b0;
        pin_function_select  <= 1'b0;
        interval_mode_select <= 1'b0;
        source_clock_select  <= 1'b0;
        interval_select      <= 2'h0;
      end else if (ctl_ok) begin
        counter_hold         <= pwdata[`CTL_HOLD];
        pin_edge_select      <= pwdata[`CTL_EDGE];
        pin_function_select  <= pwdata[`CTL_PINFN];
        interval_mode_select <= pwdata[`CTL_MODE];
        source_clock_select  <= pwdata[`CTL_SRC];
        interval_select      <= pwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Shared enable bits; one write updates both bits
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timer_irq_enable       <= 1'b0;
      nonmaskable_irq_enable <= 1'b0;
    end else if (ce) begin
      if (power_up_clear_reset) begin
        timer_irq_enable       <= 1'b0;
        nonmaskable_irq_enable <= 1'b0;
      end else if (wr_commit && hit_ie) begin
        timer_irq_enable       <= pwdata[`SFR_TIMER_BIT];
        nonmaskable_irq_enable <= pwdata[`SFR_NMI_BIT];
      end
    end
  end

  // ==========================================================
  // Timer flag: power-on reset only, so it marks watchdog resets
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timer_expiry_flag <= 1'b0;
    end else if (ce) begin
      if (key_bad || expiry) begin
        timer_expiry_flag <= 1'b1;
      end else if (timer_irq_ack && interval_mode_select) begin
        timer_expiry_flag <= 1'b0;
      end else if (sw_flag_wr) begin
        timer_expiry_flag <= pwdata[`SFR_TIMER_BIT];
      end
    end
  end

  // ==========================================================
  // Pin synchroniser; only the second flop is read
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else if (ce) begin
      pin_s1 <= rst_nmi_pin_n;
      pin_s2 <= pin_s1;
    end
  end

  // Edge select inverts the level, so toggling it can fire too
  assign nmi_level = pin_s2 ^ pin_edge_select;
  assign nmi_edge  = pin_function_select & nmi_level & ~nmi_prev;

  // NMI detector and flag; set wins over software clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_prev <= 1'b1; // Idle pin, rising select
      nmi_flag <= 1'b0;
    end else if (ce) begin
      nmi_prev <= nmi_level;
      if (nmi_edge) begin
        nmi_flag <= 1'b1;
      end else if (power_up_clear_reset) begin
        nmi_flag <= 1'b0;
      end else if (sw_flag_wr) begin
        nmi_flag <= pwdata[`SFR_NMI_BIT];
      end
    end
  end

  // ==========================================================
  // Registered requests to the rest of the chip
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timer_irq         <= 1'b0;
      nmi_irq           <= 1'b0;
      pin_reset_request <= 1'b0;
      smclk_keep_on     <= 1'b0;
    end else if (ce) begin
      timer_irq         <= timer_expiry_flag & timer_irq_enable &
                           global_irq_enable & interval_mode_select;
      nmi_irq           <= nmi_flag & nonmaskable_irq_enable;
      pin_reset_request <= ~pin_function_select & ~pin_s2;
      smclk_keep_on     <= ENHANCED_VARIANT & ~interval_mode_select &
                           ~source_clock_select;
    end
  end

  // ==========================================================
  // Source clock selection and counter
  clock_source_sync u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .smclk   (smclk),
    .aclk    (aclk),
    .src_sel (source_clock_select),
    .tick    (tick)
  );

  expiry_counter u_count (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .ce              (ce),
    .clear           (counter_clear),
    .hold            (counter_hold),
    .tick            (tick),
    .interval_select (interval_select),
    .count           (internal_counter),
    .expiry          (expiry)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_bad_key_resets: assert property (ce && key_bad |=> power_up_clear_reset)
    else $error("bad key did not raise power-up clear");
  a_read_key_field: assert property (psel && penable && pready && !pwrite && hit_ctl
    |-> prdata[15:8] == `KEY_READ && prdata[`CTL_CLEAR] == 1'b0)
    else $error("control read lacks read key");
  a_clear_restores_ctl: assert property (ce && power_up_clear_reset
    |=> ctl_read == `CTRL_RESET)
    else $error("control not restored by power-up clear");
  a_flag_survives: assert property (ce && power_up_clear_reset && timer_expiry_flag
    && !sw_flag_wr && !timer_irq_ack |=> timer_expiry_flag)
    else $error("timer flag lost on power-up clear");
  a_hold_freezes: assert property (counter_hold && !counter_clear
    |=> $stable(internal_counter))
    else $error("held counter moved");
  a_clear_zeroes: assert property (ce && counter_clear |=> internal_counter == 16'h0000)
    else $error("counter clear did not zero counter");
  a_watchdog_trip: assert property (ce && watchdog_trip
    |=> power_up_clear_reset ##1 (ctl_read == `CTRL_RESET || !ce))
    else $error("watchdog expiry did not reset");
  a_interval_no_reset: assert property (ce && expiry && interval_mode_select && !key_bad
    |=> !power_up_clear_reset && timer_expiry_flag)
    else $error("interval expiry misbehaved");
  a_irq_gated: assert property (ce && !timer_irq_enable |=> !timer_irq)
    else $error("timer irq without enable");
  a_nmi_gated: assert property (ce && !nonmaskable_irq_enable |=> !nmi_irq)
    else $error("nmi irq without enable");

  // Pin, flag and clock-request checks
  a_keep_on_gated: assert property (ce && interval_mode_select |=> !smclk_keep_on)
    else $error("clock kept on in interval mode");
  a_pin_fn_masks: assert property (ce && pin_function_select |=> !pin_reset_request)
    else $error("reset request while pin in NMI function");
  a_nmi_sets_flag: assert property (ce && nmi_edge |=> nmi_flag)
    else $error("NMI edge did not set flag");
  a_nmi_cleared_puc: assert property (ce && power_up_clear_reset && !nmi_edge |=> !nmi_flag)
    else $error("NMI flag kept over power-up clear");
  a_expiry_sets_flag: assert property (ce && expiry |=> timer_expiry_flag)
    else $error("expiry did not set timer flag");
  a_ack_clears_flag: assert property (ce && timer_irq_ack && interval_mode_select
    && !expiry && !key_bad |=> !timer_expiry_flag)
    else $error("service did not clear timer flag");
  a_mode_no_trip: assert property (ce && interval_mode_select && !key_bad |=> !power_up_clear_reset)
    else $error("power-up clear in interval mode");

  c_watchdog_reset: cover property (ce && watchdog_trip ##1 power_up_clear_reset);
  c_interval_irq: cover property (ce && expiry && interval_mode_select ##[1:3] timer_irq);
  c_key_violation: cover property (ce && key_bad);
  c_nmi_edge: cover property (ce && nmi_edge);

endmodule
`default_nettype wire

// ### design/wdt_defines.svh
// Offsets, field positions, reset values and keys of the watchdog timer.
// Assumes it is included by bare name from design files only.
//
// Contract
// - Bad write key forces power-up clear
// - Control reads return read key upper byte
// - Control resets to 6900h on power-up clear
// - Timer flag cleared by power-on reset, not power-up clear
// - Hold bit stops counter; clear runs it
// - Edge select: 0 rising, 1 falling NMI
// - Changing edge select may raise NMI
// - Pin function: 0 reset, 1 NMI
// - Mode bit: 0 watchdog, 1 interval timer
// - Counter clear zeroes counter, reads zero
// - Source select: 0 SMCLK, 1 ACLK
// - Interval codes divide 32768, 8192, 512, 64
// - Enable gates interval irq, not watchdog reset
// - NMI enable bit gates NMI interrupt
// - Enhanced variant keeps SMCLK on in watchdog mode with SMCLK source
// - Starts watchdog mode, longest interval, after clear
// - Watchdog expiry triggers power-up clear
// - Interval expiry sets flag, irq when enabled
// - Interval flag clears on service or software
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_IRQ_ENABLE 12'h000
`define IDX_IRQ_FLAG   12'h002
`define IDX_WDOG_CTRL  12'h120

// ==========================================================
// Keys and reset value of the control register
`define KEY_WRITE      8'h5a
`define KEY_READ       8'h69
`define CTRL_RESET     16'h6900

// ==========================================================
// Control field positions
`define CTL_HOLD       7
`define CTL_EDGE       6
`define CTL_PINFN      5
`define CTL_MODE       4
`define CTL_CLEAR      3
`define CTL_SRC        2

// ==========================================================
// Enable and flag bit positions
`define SFR_TIMER_BIT  0
`define SFR_NMI_BIT    4

// ==========================================================
// Counter bits below each divider (32768, 8192, 512, 64)
`define DIV_BITS_0     15
`define DIV_BITS_1     13
`define DIV_BITS_2     9
`define DIV_BITS_3     6

`endif

// ### design/wdt_pkg.sv
// Types shared by the watchdog timer files.
// Assumes nothing beyond a SystemVerilog compiler.
package wdt_pkg;

  // Bus slave state, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

  // Interval select code
  typedef logic [1:0] interval_code_t;

endpackage
